// ===== hdl/wakeup_clk_ctrl.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module wakeup_clk_ctrl
  import wakeup_clk_pkg::*;
#(
  parameter int NUM_WAKE = WAKE_W,
  parameter int NUM_LP   = 3
) (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  arst_n_in,
  // Register port
  input  wire bus_req_t              bus_req_in,
  output logic [31:0]                rdata_out,
  // Wake pins and events
  input  wire logic [NUM_WAKE-1:0]   wake_pin_in,
  input  wire logic                  radio_timer_in,
  input  wire logic                  xtal_ready_in,
  // Power requests from the core
  input  wire logic                  sleep_req_in,
  input  wire logic                  standby_req_in,
  // Low-power pad control
  input  wire logic [NUM_LP-1:0]     lp_pad_in,
  output logic [NUM_LP-1:0]          lp_pad_out,
  output logic [NUM_LP-1:0]          lp_pad_oe_out,
  output logic [NUM_LP-1:0]          lp_pad_drive_out,
  output logic [NUM_LP-1:0]          lp_pad_pull_out,
  // Clock control
  output logic                       hs_xtal_sel_out,
  output logic                       ring_osc_en_out,
  output logic                       lf_clk_en_out,
  output logic                       lf_xtal_sel_out,
  output logic                       periph_half_rate_out,
  output logic                       cpu_clk_en_out,
  output logic                       ram_clk_en_out,
  output logic [GATE_W-1:0]          periph_clk_en_out,
  output logic                       low_power_out,
  output logic                       core_rst_n_out
);

  if (NUM_WAKE != WAKE_W || NUM_LP < 1 || NUM_LP > NUM_WAKE) begin : g_chk
    $error("wakeup_clk_ctrl: unsupported pin counts");
  end

  // Registers
  logic [4:0]        wake_level_register_r;
  logic [4:0]        wake_enable_register_r;
  logic              fast_crystal_flag_r;
  logic [4:0]        lowpower_output_enable_bits_r;
  logic [4:0]        lowpower_output_value_bits_r;
  logic [4:0]        lowpower_drive_bits_r;
  logic [4:0]        lowpower_pull_bits_r;
  logic [GATE_W-1:0] clk_gate_r;
  logic [1:0]        mode_ctrl_r;
  logic [GATE_W-1:0] gate_nxt;

  // Synchronisers
  logic [NUM_WAKE-1:0] wake_meta_r;
  logic [NUM_WAKE-1:0] wake_sync_r;
  logic [NUM_LP-1:0]   pad_meta_r;
  logic [NUM_LP-1:0]   pad_sync_r;
  logic                xtal_meta_r;
  logic                xtal_sync_r;

  power_state_t state_r;
  power_state_t state_nxt;
  logic [3:0]   rst_cnt_r;
  logic         wake_hit;
  logic         low_power;
  logic         xtal_run;
  logic         cpu_on;
  logic [31:0]  rdata_nxt;

  // Pins from outside pass two flops first
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_meta_r <= '0;
      wake_sync_r <= '0;
      pad_meta_r  <= '0;
      pad_sync_r  <= '0;
      xtal_meta_r <= 1'h0;
      xtal_sync_r <= 1'h0;
    end else begin
      wake_meta_r <= wake_pin_in;
      wake_sync_r <= wake_meta_r;
      pad_meta_r  <= lp_pad_in;
      pad_sync_r  <= pad_meta_r;
      xtal_meta_r <= xtal_ready_in;
      xtal_sync_r <= xtal_meta_r;
    end
  end

  // Register writes, field bits only
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_level_register_r         <= RST_WAKE_LEVEL;
      wake_enable_register_r        <= RST_WAKE_ENABLE;
      fast_crystal_flag_r           <= RST_XTAL_SEL;
      lowpower_output_enable_bits_r <= RST_LP_OE;
      lowpower_output_value_bits_r  <= RST_LP_OUT;
      lowpower_drive_bits_r         <= RST_LP_DRIVE;
      lowpower_pull_bits_r          <= RST_LP_PULL;
      clk_gate_r                    <= RST_CLK_GATE;
      mode_ctrl_r                   <= RST_MODE_CTRL;
    end else if (bus_req_in.wr) begin
      case (bus_req_in.addr)
        OFF_WAKE_LEVEL: begin
          wake_level_register_r <= bus_req_in.wdata[4:0];
        end
        OFF_WAKE_ENABLE: begin
          wake_enable_register_r <= bus_req_in.wdata[4:0];
        end
        OFF_XTAL_SEL: begin
          fast_crystal_flag_r <= bus_req_in.wdata[0];
        end
        OFF_LP_OE: begin
          lowpower_output_enable_bits_r <= bus_req_in.wdata[4:0];
        end
        OFF_LP_OUT: begin
          lowpower_output_value_bits_r <= bus_req_in.wdata[4:0];
        end
        OFF_LP_DRIVE: begin
          lowpower_drive_bits_r <= bus_req_in.wdata[4:0];
        end
        OFF_LP_PULL: begin
          lowpower_pull_bits_r <= bus_req_in.wdata[4:0];
        end
        OFF_CLK_GATE: begin
          clk_gate_r <= bus_req_in.wdata[GATE_W-1:0];
        end
        OFF_MODE_CTRL: begin
          mode_ctrl_r <= bus_req_in.wdata[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped and reserved read zero
  always_comb begin
    rdata_nxt = '0;
    case (bus_req_in.addr)
      OFF_WAKE_LEVEL:  rdata_nxt[4:0] = wake_level_register_r;
      OFF_WAKE_ENABLE: rdata_nxt[4:0] = wake_enable_register_r;
      OFF_XTAL_SEL:    rdata_nxt[0]   = fast_crystal_flag_r;
      OFF_LP_OE:       rdata_nxt[4:0] = lowpower_output_enable_bits_r;
      OFF_LP_OUT:      rdata_nxt[4:0] = lowpower_output_value_bits_r;
      OFF_LP_DRIVE:    rdata_nxt[4:0] = lowpower_drive_bits_r;
      OFF_LP_PULL:     rdata_nxt[4:0] = lowpower_pull_bits_r;
      OFF_CLK_GATE:    rdata_nxt[GATE_W-1:0] = clk_gate_r;
      OFF_MODE_CTRL:   rdata_nxt[1:0] = mode_ctrl_r;
      OFF_STATUS: begin
        rdata_nxt[STATE_W-1:0]              = state_r;
        rdata_nxt[STATE_W]                  = xtal_sync_r;
        rdata_nxt[STATE_W+1+NUM_WAKE-1:STATE_W+1] = wake_sync_r;
        rdata_nxt[16+NUM_LP-1:16]           = pad_sync_r;
      end
      default:         rdata_nxt = '0;
    endcase
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= '0;
    end else if (bus_req_in.rd) begin
      rdata_out <= rdata_nxt;
    end else begin
      rdata_out <= '0;
    end
  end

  // Pin matches level and is enabled
  assign wake_hit = |(wake_enable_register_r & ~(wake_sync_r ^ wake_level_register_r));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_PREACTIVE: begin
        if (xtal_sync_r && !mode_ctrl_r[MODE_STAY_RO]) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (standby_req_in) begin
          state_nxt = ST_STANDBY;
        end else if (sleep_req_in) begin
          state_nxt = ST_SLEEP;
        end
      end
      // Pins or radio timer end sleep
      ST_SLEEP: begin
        if (wake_hit || radio_timer_in) begin
          state_nxt = ST_WAKE;
        end
      end
      // Radio timers stop in standby, pins only
      ST_STANDBY: begin
        if (wake_hit) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (rst_cnt_r == CORE_RST_CYCLES) begin
          state_nxt = ST_PREACTIVE;
        end
      end
      default: state_nxt = ST_PREACTIVE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_PREACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Cycles spent in the wake state
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_cnt_r <= '0;
    end else if (state_r == ST_WAKE) begin
      rst_cnt_r <= rst_cnt_r + 4'h1;
    end else begin
      rst_cnt_r <= '0;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_rst_n_out <= 1'h0;
    end else begin
      core_rst_n_out <= (state_nxt != ST_WAKE);
    end
  end

  assign low_power = (state_nxt == ST_SLEEP) || (state_nxt == ST_STANDBY);
  assign xtal_run  = (state_nxt == ST_ACTIVE);
  assign cpu_on    = (state_nxt == ST_ACTIVE) || (state_nxt == ST_PREACTIVE);

  // Pads: owned by this block only in low-power states
  for (genvar i = 0; i < NUM_LP; i++) begin : g_pad
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        lp_pad_oe_out[i]    <= 1'h0;
        lp_pad_out[i]       <= 1'h0;
        lp_pad_drive_out[i] <= 1'h0;
        lp_pad_pull_out[i]  <= 1'h0;
      end else begin
        lp_pad_oe_out[i]    <= low_power & lowpower_output_enable_bits_r[i];
        lp_pad_out[i]       <= low_power & lowpower_output_enable_bits_r[i]
                               & lowpower_output_value_bits_r[i];
        lp_pad_drive_out[i] <= low_power & lowpower_drive_bits_r[i];
        lp_pad_pull_out[i]  <= low_power & lowpower_pull_bits_r[i];
      end
    end
  end

  // Ring runs only before crystal takes over
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hs_xtal_sel_out <= 1'h0;
      ring_osc_en_out <= 1'h1;
    end else begin
      hs_xtal_sel_out <= xtal_run;
      ring_osc_en_out <= (state_nxt == ST_PREACTIVE) || (state_nxt == ST_WAKE);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lf_clk_en_out   <= 1'h1;
      lf_xtal_sel_out <= 1'h0;
    end else begin
      lf_clk_en_out   <= (state_nxt != ST_STANDBY);
      lf_xtal_sel_out <= mode_ctrl_r[MODE_LF_XTAL];
    end
  end

  // Rest of tree halved at 32 MHz
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      periph_half_rate_out <= 1'h0;
    end else begin
      periph_half_rate_out <= xtal_run & fast_crystal_flag_r;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cpu_clk_en_out <= 1'h1;
    end else begin
      cpu_clk_en_out <= cpu_on;
    end
  end

  // RAM off only if cpu, SPI, radio all off
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ram_clk_en_out <= 1'h1;
    end else begin
      ram_clk_en_out <= cpu_on | (clk_gate_r[PER_SPI] & ~low_power)
                        | (clk_gate_r[PER_RADIO] & xtal_run);
    end
  end

  always_comb begin
    gate_nxt                = clk_gate_r & {GATE_W{~low_power}};
    gate_nxt[PER_RADIO]     = clk_gate_r[PER_RADIO] & xtal_run;
    gate_nxt[PER_RADIO_GEN] = clk_gate_r[PER_RADIO_GEN] & xtal_run;
  end

  // Software gates, none while in low power
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // Radio gates shut, ring oscillator runs out of reset
      periph_clk_en_out                <= RST_CLK_GATE;
      periph_clk_en_out[PER_RADIO]     <= 1'h0;
      periph_clk_en_out[PER_RADIO_GEN] <= 1'h0;
    end else begin
      periph_clk_en_out <= gate_nxt;
    end
  end

  // Low-power flag for the pad ring
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_power_out <= 1'h0;
    end else begin
      low_power_out <= low_power;
    end
  end

endmodule
`default_nettype wire

// ===== hdl/wakeup_clk_pkg.sv
package wakeup_clk_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_WAKE_LEVEL  = 8'h00;
  localparam logic [7:0] OFF_WAKE_ENABLE = 8'h04;
  localparam logic [7:0] OFF_XTAL_SEL    = 8'h08;
  localparam logic [7:0] OFF_LP_OE       = 8'h0C;
  localparam logic [7:0] OFF_LP_OUT      = 8'h10;
  localparam logic [7:0] OFF_LP_DRIVE    = 8'h14;
  localparam logic [7:0] OFF_LP_PULL     = 8'h18;
  localparam logic [7:0] OFF_CLK_GATE    = 8'h1C;
  localparam logic [7:0] OFF_MODE_CTRL   = 8'h20;
  localparam logic [7:0] OFF_STATUS      = 8'h24;

  // Field widths
  localparam int WAKE_W  = 5;
  localparam int GATE_W  = 17;
  localparam int STATE_W = 5;

  // Reset values
  localparam logic [4:0]  RST_WAKE_LEVEL  = 5'h00;
  localparam logic [4:0]  RST_WAKE_ENABLE = 5'h07;
  localparam logic        RST_XTAL_SEL    = 1'h0;
  localparam logic [4:0]  RST_LP_OE       = 5'h07;
  localparam logic [4:0]  RST_LP_OUT      = 5'h00;
  localparam logic [4:0]  RST_LP_DRIVE    = 5'h00;
  localparam logic [4:0]  RST_LP_PULL     = 5'h00;
  localparam logic [16:0] RST_CLK_GATE    = 17'h0FFFF;
  localparam logic [1:0]  RST_MODE_CTRL   = 2'h0;

  // Peripheral clock gate bit positions
  localparam int PER_DMA       = 0;
  localparam int PER_RADIO     = 1;
  localparam int PER_RADIO_GEN = 2;
  localparam int PER_RNG       = 3;
  localparam int PER_FLASH     = 4;
  localparam int PER_GPIO      = 5;
  localparam int PER_SYSCTRL   = 6;
  localparam int PER_UART      = 7;
  localparam int PER_SPI       = 8;
  localparam int PER_I2C_A     = 9;
  localparam int PER_I2C_B     = 10;
  localparam int PER_ADC       = 11;
  localparam int PER_MFT_A     = 12;
  localparam int PER_MFT_B     = 13;
  localparam int PER_RTC       = 14;
  localparam int PER_WDOG      = 15;
  localparam int PER_PKA       = 16;

  // Mode control fields (lf source, ring oscillator kept)
  localparam int MODE_LF_XTAL  = 0;
  localparam int MODE_STAY_RO  = 1;

  // Last wake-state count; the core reset pulse after wake-up lasts one cycle more
  localparam logic [3:0] CORE_RST_CYCLES = 4'h4;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Power states, one-hot
  typedef enum logic [4:0] {
    ST_PREACTIVE = 5'h01,
    ST_ACTIVE    = 5'h02,
    ST_SLEEP     = 5'h04,
    ST_STANDBY   = 5'h08,
    ST_WAKE      = 5'h10
  } power_state_t;

endpackage

// ===== tb/wake_source.sv
`timescale 1ns/1ns
`default_nettype none
module wake_source (
  // Control from bench
  input  wire logic       clk_in,
  input  wire logic       arm_in,
  input  wire logic [4:0] mask_in,
  input  wire logic [4:0] level_in,
  input  wire logic [7:0] delay_in,
  input  wire logic [2:0] pad_oe_in,
  input  wire logic [2:0] pad_val_in,
  // Pins
  output logic      [4:0] pin_out,
  output logic      [2:0] pad_out
);
  logic [7:0] cnt_r;
  // Slow answer: delay before asserting
  always_ff @(posedge clk_in) begin
    if (!arm_in) cnt_r <= 8'h00;
    else if (cnt_r != delay_in) cnt_r <= cnt_r + 8'h01;
  end
  assign pin_out = (arm_in && cnt_r == delay_in) ?
    ((level_in & mask_in) | (~level_in & ~mask_in)) : ~level_in;
  assign pad_out = (pad_val_in & pad_oe_in) | ~pad_oe_in;
endmodule
`default_nettype wire

// ===== tb/wakeup_clk_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module wakeup_clk_ctrl_bench;
  import wakeup_clk_pkg::*;
  logic mclk_in, arst_n_in, radio_tm, xtal_rdy, slp, stby, arm;
  bus_req_t req;
  logic [31:0] rdata;
  logic [4:0] pins, mask, lvl;
  logic [7:0] dly;
  logic [2:0] pad_i, pad_o, pad_oe, pad_dr, pad_pu;
  logic hs, ring, lfe, lfx, half, cpu, ram, lp, crst_n;
  logic [GATE_W-1:0] gate;
  int error_cnt, samples_checked, cyc;
  logic [31:0] rows [10][3] = '{'{32'h00, 32'h0, 32'h1F}, '{32'h04, 32'h7, 32'h1F},
    '{32'h08, 32'h0, 32'h1}, '{32'h0C, 32'h7, 32'h1F}, '{32'h10, 32'h0, 32'h1F},
    '{32'h14, 32'h0, 32'h1F}, '{32'h18, 32'h0, 32'h1F}, '{32'h1C, 32'h0FFFF, 32'h1FFFF},
    '{32'h20, 32'h0, 32'h3}, '{32'h3C, 32'h0, 32'h0}};
  wakeup_clk_ctrl DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .bus_req_in(req),
    .rdata_out(rdata), .wake_pin_in(pins), .radio_timer_in(radio_tm),
    .xtal_ready_in(xtal_rdy), .sleep_req_in(slp), .standby_req_in(stby),
    .lp_pad_in(pad_i), .lp_pad_out(pad_o), .lp_pad_oe_out(pad_oe),
    .lp_pad_drive_out(pad_dr), .lp_pad_pull_out(pad_pu), .hs_xtal_sel_out(hs),
    .ring_osc_en_out(ring), .lf_clk_en_out(lfe), .lf_xtal_sel_out(lfx),
    .periph_half_rate_out(half), .cpu_clk_en_out(cpu), .ram_clk_en_out(ram),
    .periph_clk_en_out(gate), .low_power_out(lp), .core_rst_n_out(crst_n));
  wake_source far (.clk_in(mclk_in), .arm_in(arm), .mask_in(mask), .level_in(lvl),
    .delay_in(dly), .pad_oe_in(pad_oe), .pad_val_in(pad_o), .pin_out(pins),
    .pad_out(pad_i));
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in) req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_in) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_in) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk_in) req <= '0;
    #1 chk(rdata, e, "read data");
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge mclk_in) {slp, stby, radio_tm} <= v;
    @(posedge mclk_in) {slp, stby, radio_tm} <= 3'b000;
    #1;
  endtask
  task automatic wait_lp(input logic v);
    for (int i = 0; i < 30 && lp !== v; i++) begin
      @(posedge mclk_in);
      #1;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {arst_n_in, radio_tm, xtal_rdy, slp, stby, arm, req} = '0;
    {mask, lvl, dly} = '0;
    repeat (4) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    // Reset value, all-ones write, restore
    foreach (rows[i]) begin
      rd(rows[i][0][7:0], rows[i][1]);
      wr(rows[i][0][7:0], 32'hFFFFFFFF);
      rd(rows[i][0][7:0], rows[i][2]);
      wr(rows[i][0][7:0], rows[i][1]);
    end
    $display("register table done");
    wr(OFF_XTAL_SEL, 32'h1);
    wr(OFF_LP_OE, 32'h5);
    wr(OFF_LP_OUT, 32'h7);
    wr(OFF_LP_DRIVE, 32'h2);
    wr(OFF_LP_PULL, 32'h1);
    wr(OFF_MODE_CTRL, 32'h1);
    wr(OFF_WAKE_LEVEL, 32'h10);
    wr(OFF_WAKE_ENABLE, 32'h10);
    // Pins idle away from the new wake level before sleep
    @(posedge mclk_in) {xtal_rdy, lvl} <= {1'b1, 5'h10};
    repeat (6) @(posedge mclk_in);
    chk({half, lfx, ram, gate}, {3'b111, 17'h0FFFF}, "active clocks");
    pulse(3'b100);
    chk({lp, cpu, pad_oe, pad_o}, {2'b10, 3'h5, 3'h5}, "sleep pads");
    chk({pad_dr, pad_pu}, {3'h2, 3'h1}, "drive pull");
    chk({lfe, ram, gate}, {2'b10, 17'h0}, "sleep clocks");
    chk(pad_i, 3'h7, "pad wire");
    {arm, mask, lvl, dly} <= {1'b1, 5'h01, 5'h10, 8'h00};
    repeat (10) @(posedge mclk_in);
    chk(lp, 1'b1, "disabled pin woke");
    {arm, mask, dly} <= {1'b0, 5'h10, 8'h08};
    @(posedge mclk_in) arm <= 1'b1;
    wait_lp(1'b0);
    chk({lp, crst_n}, 2'b00, "pin wake");
    arm <= 1'b0;
    $display("sleep wake done");
    repeat (10) @(posedge mclk_in);
    pulse(3'b010);
    pulse(3'b001);
    repeat (8) @(posedge mclk_in);
    chk({lp, lfe, cpu}, 3'b100, "timer in standby");
    arm <= 1'b1;
    wait_lp(1'b0);
    chk({lp, crst_n}, 2'b00, "standby wake");
    arm <= 1'b0;
    repeat (10) @(posedge mclk_in);
    pulse(3'b100);
    pulse(3'b001);
    wait_lp(1'b0);
    chk({lp, crst_n}, 2'b00, "timer wake");
    $display("standby and timer done");
    @(posedge mclk_in) arst_n_in <= 1'b0;
    #1 chk({lp, cpu, ram, ring, hs, crst_n, gate}, {6'b011100, 17'h0FFF9}, "mid reset");
    repeat (4) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    rd(OFF_LP_OE, 32'h7);
    repeat (2) @(posedge mclk_in);
    #1 chk({hs, ring, crst_n}, 3'b101, "restart on crystal");
    $display("mid-run reset done");
    finish_test();
  end
endmodule
bind wakeup_clk_ctrl wakeup_clk_monitor #(.NUM_LP(NUM_LP)) mon (.mclk_in(mclk_in),
  .arst_n_in(arst_n_in), .bus_req_in(bus_req_in), .rdata_out(rdata_out),
  .sleep_req_in(sleep_req_in), .lp_pad_out(lp_pad_out), .lp_pad_oe_out(lp_pad_oe_out),
  .hs_xtal_sel_out(hs_xtal_sel_out), .ring_osc_en_out(ring_osc_en_out),
  .periph_half_rate_out(periph_half_rate_out), .cpu_clk_en_out(cpu_clk_en_out),
  .ram_clk_en_out(ram_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
  .low_power_out(low_power_out), .core_rst_n_out(core_rst_n_out));
`default_nettype wire

// ===== tb/wakeup_clk_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module wakeup_clk_monitor
  import wakeup_clk_pkg::*;
#(
  parameter int NUM_LP = 3
) (
  // Clock and reset
  input wire logic              mclk_in,
  input wire logic              arst_n_in,
  // Watched ports
  input wire bus_req_t          bus_req_in,
  input wire logic [31:0]       rdata_out,
  input wire logic              sleep_req_in,
  input wire logic [NUM_LP-1:0] lp_pad_out,
  input wire logic [NUM_LP-1:0] lp_pad_oe_out,
  input wire logic              hs_xtal_sel_out,
  input wire logic              ring_osc_en_out,
  input wire logic              periph_half_rate_out,
  input wire logic              cpu_clk_en_out,
  input wire logic              ram_clk_en_out,
  input wire logic [GATE_W-1:0] periph_clk_en_out,
  input wire logic              low_power_out,
  input wire logic              core_rst_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  cpu_gate_a: assert property (low_power_out |-> !cpu_clk_en_out)
    else $error("cpu clock runs in low power");
  ram_gate_a: assert property (ram_clk_en_out == (cpu_clk_en_out |
    periph_clk_en_out[PER_SPI] | periph_clk_en_out[PER_RADIO]))
    else $error("ram gate differs from cpu spi radio");
  pad_drive_a: assert property ((lp_pad_out & ~lp_pad_oe_out) == '0)
    else $error("pad value driven while disabled");
  radio_ring_a: assert property (ring_osc_en_out |-> !periph_clk_en_out[PER_RADIO])
    else $error("radio clocked from ring oscillator");
  half_rate_a: assert property (periph_half_rate_out |-> hs_xtal_sel_out)
    else $error("half rate without crystal");
  ring_start_a: assert property (!hs_xtal_sel_out && !low_power_out |-> ring_osc_en_out)
    else $error("no ring clock before crystal");
  wake_reset_a: assert property ($fell(low_power_out) |->
    !core_rst_n_out [*5] ##1 core_rst_n_out)
    else $error("core reset pulse wrong after wake");
  sleep_entry_a: assert property (sleep_req_in && hs_xtal_sel_out |=> low_power_out)
    else $error("sleep request not taken");
  read_idle_a: assert property (!$past(bus_req_in.rd) |-> rdata_out == '0)
    else $error("read data outside read cycle");
  cover property ($rose(low_power_out));
  cover property ($fell(low_power_out));
  cover property (periph_half_rate_out);
endmodule
`default_nettype wire
